/* inc/qwl_pkg.sv */
// Package: constants, types and register map of the queued write and log command decoder
package qwl_pkg;
    // ==========================================================
    // Command and field layout
    localparam logic [7:0] QWL_OP_QWRITE   = 8'h61;
    localparam logic [7:0] QWL_OP_LOGWRITE = 8'h3F;
    localparam int         QWL_TAG_HI      = 7;
    localparam int         QWL_TAG_LO      = 3;
    localparam int         QWL_URGENCY_CLASS_HI     = 15;
    localparam int         QWL_URGENCY_CLASS_LO     = 14;
    localparam int         QWL_DEV_FMW     = 7;
    localparam int         QWL_DEV_ONE     = 6;
    localparam int         QWL_DEV_ZERO    = 4;
    localparam int         QWL_DL_COARSE   = 7;
    localparam logic [16:0] QWL_FULL_COUNT = 17'h10000;
    localparam logic [1:0] QWL_URGENCY_CLASS_NORMAL = 2'h0;
    localparam logic [1:0] QWL_URGENCY_CLASS_ISO    = 2'h1;
    localparam logic [1:0] QWL_URGENCY_CLASS_HIGH   = 2'h2;
    // Error and status bits
    localparam int         QWL_ERR_LINK    = 7;
    localparam int         QWL_ERR_MISS    = 4;
    localparam int         QWL_ERR_ABORT   = 2;
    localparam int         QWL_ST_FAULT    = 5;
    localparam int         QWL_ST_SENSE    = 1;
    localparam int         QWL_ST_ERR      = 0;
    // ==========================================================
    // Timing
    localparam int         QWL_CLK_HZ      = 10000000;
    localparam int         QWL_FINE_MS     = 10;
    localparam int         QWL_COARSE_MS   = 500;
    localparam int         QWL_TICK_CYC    = QWL_CLK_HZ / 1000 * QWL_FINE_MS;
    localparam int         QWL_COARSE_MUL  = QWL_COARSE_MS / QWL_FINE_MS;
    // ==========================================================
    // Register map (APB byte addresses)
    localparam logic [7:0] QWL_A_CMD    = 8'h00;
    localparam logic [7:0] QWL_A_FEAT   = 8'h04;
    localparam logic [7:0] QWL_A_CNT    = 8'h08;
    localparam logic [7:0] QWL_A_LBALO  = 8'h0C;
    localparam logic [7:0] QWL_A_LBAHI  = 8'h10;
    localparam logic [7:0] QWL_A_DEVDL  = 8'h14;
    localparam logic [7:0] QWL_A_CTRL   = 8'h18;
    localparam logic [7:0] QWL_A_RES    = 8'h1C;
    localparam logic [7:0] QWL_A_LOGCFG = 8'h20;
    localparam logic [7:0] QWL_A_EVENT  = 8'h24;
    localparam logic [7:0] QWL_A_OUTST  = 8'h28;
    localparam logic [7:0] QWL_A_SLOT   = 8'h2C;
    localparam logic [7:0] QWL_A_SLOTLO = 8'h30;
    localparam logic [7:0] QWL_A_SLOTHI = 8'h34;
    localparam logic [31:0] QWL_BAD_DATA = 32'hDEAD0BAD;

    typedef struct packed {
        logic [15:0] lba_hi;
        logic [31:0] lba_lo;
        logic [16:0] count;
        logic [1:0]  urgency_class;
        logic [13:0] limit_ticks;
        logic        force_media_write;
        logic        valid;
        logic        expired;
    } qwl_slot_t;

    typedef enum logic [1:0] {
        QWL_IDLE = 2'b00,
        QWL_DEC  = 2'b01,
        QWL_DONE = 2'b11
    } qwl_state_t;
endpackage

/* hdl/qwl_decoder.sv */
// Module: queued write and log command decoder with APB register file
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module qwl_decoder
    import qwl_pkg::*;
#(
    parameter int SLOTS     = 32,
    parameter int TICK_CYC  = QWL_TICK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        write_cache_on,
    input  wire logic        media_done,
    input  wire logic [4:0]  media_done_slot,
    input  wire logic        media_fail,
    input  wire logic        drb_done,
    input  wire logic        link_crc_err,
    output logic             drb_event
);
    // ==========================================================
    // State
    typedef struct packed {
        qwl_state_t  st;
        logic [7:0]  cmd;
        logic [15:0] feat;
        logic [15:0] cnt;
        logic [31:0] lba_lo;
        logic [15:0] lba_hi;
        logic [7:0]  dev;
        logic [7:0]  dl;
        logic [7:0]  err;
        logic [7:0]  stat;
        logic [31:0] logcfg;
        logic [15:0] events;
        logic        ack;
        logic [4:0]  sel;
        logic [23:0] tick;
        logic        drb;
        logic [31:0] rdata;
        logic        slverr;
    } qwl_regs_t;

    qwl_regs_t r_q;
    qwl_regs_t r_d;
    qwl_slot_t slot_q [SLOTS];
    qwl_slot_t slot_d [SLOTS];

    // ==========================================================
    // Functions
    function automatic logic [13:0] dl_ticks(input logic [7:0] code);
        logic [13:0] base;
        base = {7'h00, code[6:0]} + 14'h0001;
        // Coarse unit is fifty fine ticks, so one counter serves both
        if (code[QWL_DL_COARSE]) begin
            dl_ticks = 14'(base * QWL_COARSE_MUL);
        end else begin
            dl_ticks = base;
        end
    endfunction

    function automatic logic [16:0] sect_count(input logic [15:0] f);
        sect_count = (f == 16'h0000) ? QWL_FULL_COUNT : {1'b0, f};
    endfunction

    // ==========================================================
    // Decode helpers
    logic        access;
    logic        tick_hit;
    logic [4:0]  tag;
    logic [1:0]  urg;
    logic [7:0]  log_id;
    logic [15:0] page;
    logic [15:0] pcnt;
    logic [15:0] log_size;
    logic        log_ro;
    logic        log_sup;
    logic        log_avail;
    logic        log_csum_bad;
    logic [16:0] page_end;
    logic [31:0] outst;

    assign access   = psel && penable;
    assign tick_hit = (r_q.tick == 24'(TICK_CYC - 1));
    assign tag      = r_q.cnt[QWL_TAG_HI:QWL_TAG_LO];
    assign urg      = r_q.cnt[QWL_URGENCY_CLASS_HI:QWL_URGENCY_CLASS_LO];
    assign log_id   = r_q.lba_lo[7:0];
    assign page     = {r_q.lba_hi[7:0], r_q.lba_lo[15:8]};
    assign pcnt     = r_q.cnt;
    // Log directory entry for the selected log, supplied by firmware
    assign log_size     = r_q.logcfg[15:0];
    assign log_ro       = r_q.logcfg[16];
    assign log_sup      = r_q.logcfg[17];
    assign log_avail    = r_q.logcfg[18];
    assign log_csum_bad = r_q.logcfg[19];
    assign page_end     = {1'b0, page} + {1'b0, pcnt};

    always_comb begin
        outst = 32'h0000_0000;
        for (int i = 0; i < SLOTS; i++) begin
            outst[i] = slot_q[i].valid;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        r_d     = r_q;
        slot_d  = slot_q;
        r_d.ack = 1'b0;
        r_d.drb = 1'b0;
        r_d.tick = tick_hit ? 24'h000000 : r_q.tick + 24'h000001;

        // Deadline countdown; expiry only flags, the command keeps running
        for (int i = 0; i < SLOTS; i++) begin
            if (tick_hit && slot_q[i].valid && slot_q[i].urgency_class == QWL_URGENCY_CLASS_ISO) begin
                if (slot_q[i].limit_ticks != 14'h0000) begin
                    slot_d[i].limit_ticks = slot_q[i].limit_ticks - 14'h0001;
                end else begin
                    slot_d[i].expired = 1'b1;
                end
            end
        end

        // Media side completion frees the slot
        if (media_done) begin
            // With force flag or cache off, only the media ack ends it
            slot_d[media_done_slot].valid = 1'b0;
            r_d.events[0] = 1'b1;
        end
        if (drb_done && r_q.cmd == QWL_OP_LOGWRITE) begin
            r_d.drb = 1'b1;
        end

        case (r_q.st)
            QWL_IDLE: begin
            end
            QWL_DEC: begin
                r_d.err  = 8'h00;
                r_d.stat = 8'h00;
                r_d.st   = QWL_DONE;
                if (r_q.cmd == QWL_OP_QWRITE) begin
                    // Device byte bits are trusted to the host
                    // Unique, in-range slot id trusted to the host
                    slot_d[tag].valid         = 1'b1;
                    slot_d[tag].expired       = 1'b0;
                    slot_d[tag].lba_lo        = r_q.lba_lo;
                    slot_d[tag].lba_hi        = r_q.lba_hi;
                    slot_d[tag].count         = sect_count(r_q.feat);
                    slot_d[tag].urgency_class = urg;
                    slot_d[tag].force_media_write = r_q.dev[QWL_DEV_FMW];
                    if (urg == QWL_URGENCY_CLASS_ISO) begin
                        slot_d[tag].limit_ticks = dl_ticks(r_q.dl);
                    end else begin
                        slot_d[tag].limit_ticks = 14'h0000;
                    end
                    // Early ack allowed only when cached and not forced
                    if (write_cache_on && !r_q.dev[QWL_DEV_FMW]) begin
                        r_d.events[1] = 1'b1;
                    end
                end else if (r_q.cmd == QWL_OP_LOGWRITE) begin
                    if (pcnt == 16'h0000 || pcnt > log_size || log_ro || !log_sup ||
                        r_q.feat != 16'h0000 || r_q.lba_lo[31:16] != 16'h0000 ||
                        r_q.lba_hi[15:8] != 8'h00 || page_end > {1'b0, log_size}) begin
                        r_d.err[QWL_ERR_ABORT] = 1'b1;
                        r_d.stat[QWL_ST_ERR]   = 1'b1;
                    end else if (!log_avail || log_csum_bad) begin
                        r_d.err[QWL_ERR_MISS] = 1'b1;
                        r_d.stat[QWL_ST_ERR]  = 1'b1;
                    end
                end else begin
                    r_d.err[QWL_ERR_ABORT] = 1'b1;
                    r_d.stat[QWL_ST_ERR]   = 1'b1;
                end
            end
            QWL_DONE: begin
                r_d.st = QWL_IDLE;
            end
            default: begin
                r_d.st = QWL_IDLE;
            end
        endcase

        if (media_fail) begin
            // Media engine halts at the failing sector; slot is retired
            slot_d[media_done_slot].valid = 1'b0;
            r_d.err[QWL_ERR_ABORT]  = 1'b1;
            r_d.stat                = 8'h00;
            r_d.stat[QWL_ST_ERR]    = 1'b1;
            r_d.stat[QWL_ST_FAULT]  = 1'b1;
            r_d.stat[QWL_ST_SENSE]  = 1'b1;
        end
        if (link_crc_err) begin
            r_d.err[QWL_ERR_LINK] = 1'b1;
            r_d.stat[QWL_ST_ERR]  = 1'b1;
        end

        // APB slave, zero wait states; read data and error held until next setup
        if (psel && !penable) begin
            r_d.slverr = 1'b0;
            case (paddr)
                QWL_A_CMD:    r_d.rdata = {24'h000000, r_q.cmd};
                QWL_A_FEAT:   r_d.rdata = {16'h0000, r_q.feat};
                QWL_A_CNT:    r_d.rdata = {16'h0000, r_q.cnt};
                QWL_A_LBALO:  r_d.rdata = r_q.lba_lo;
                QWL_A_LBAHI:  r_d.rdata = {16'h0000, r_q.lba_hi};
                QWL_A_DEVDL:  r_d.rdata = {16'h0000, r_q.dev, r_q.dl};
                QWL_A_CTRL:   r_d.rdata = {30'h0000_0000, r_q.st != QWL_IDLE, 1'b0};
                QWL_A_RES:    r_d.rdata = {16'h0000, r_q.err, r_q.stat};
                QWL_A_LOGCFG: r_d.rdata = r_q.logcfg;
                QWL_A_EVENT:  r_d.rdata = {16'h0000, r_q.events};
                QWL_A_OUTST:  r_d.rdata = outst;
                QWL_A_SLOT:   r_d.rdata = {27'h0000000, r_q.sel};
                QWL_A_SLOTLO: r_d.rdata = slot_q[r_q.sel].lba_lo;
                QWL_A_SLOTHI: r_d.rdata = {slot_q[r_q.sel].expired,
                                           slot_q[r_q.sel].force_media_write,
                                           slot_q[r_q.sel].urgency_class,
                                           slot_q[r_q.sel].limit_ticks,
                                           slot_q[r_q.sel].lba_hi[13:0]};
                default: begin
                    r_d.rdata  = QWL_BAD_DATA;
                    r_d.slverr = 1'b1;
                end
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                QWL_A_CMD:    r_d.cmd    = pwdata[7:0];
                QWL_A_FEAT:   r_d.feat   = pwdata[15:0];
                QWL_A_CNT:    r_d.cnt    = pwdata[15:0];
                QWL_A_LBALO:  r_d.lba_lo = pwdata;
                QWL_A_LBAHI:  r_d.lba_hi = pwdata[15:0];
                QWL_A_DEVDL: begin
                    r_d.dev = pwdata[15:8];
                    r_d.dl  = pwdata[7:0];
                end
                QWL_A_CTRL: begin
                    if (pwdata[0] && r_q.st == QWL_IDLE) begin
                        r_d.st = QWL_DEC;
                    end
                end
                QWL_A_LOGCFG: r_d.logcfg = pwdata;
                // Write one to clear; a same-cycle hardware set of a bit that was clear wins
                QWL_A_EVENT:  r_d.events = r_q.events & ~pwdata[15:0] |
                                           (r_d.events & ~r_q.events);
                QWL_A_SLOT:   r_d.sel    = pwdata[4:0];
                default: begin
                end
            endcase
        end
    end

    assign pready    = 1'b1;
    assign pslverr   = access ? r_q.slverr : 1'b0;
    assign prdata    = r_q.rdata;
    assign drb_event = r_q.drb;

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            r_q    <= r_d;
            slot_q <= slot_d;
        end
    end
endmodule // qwl_decoder

/* tb/qwl_decoder_asserts.sv */
// Checker: port-level assertions for the queued write and log decoder
`timescale 1ns/1ps
module qwl_decoder_chk
    import qwl_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        drb_done,
    input wire logic        drb_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Register bus
    AST_READY: assert property (pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    AST_MAPPED: assert property (psel && penable && paddr <= 8'h34 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("pslverr on mapped word");
    AST_BAD_READ: assert property (psel && penable && !pwrite && pslverr |-> prdata == QWL_BAD_DATA)
        else $error("unmapped read data");
    // Read data may only move at a setup edge, else polling races the result
    AST_RD_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata moved");
    AST_RST_VAL: assert property ($rose(presetn) |-> prdata == 32'h0 && !pslverr && !drb_event)
        else $error("reset values");
    // ==========================================================
    // Data request block events
    AST_DRB_CAUSE: assert property (drb_event |-> $past(drb_done))
        else $error("event without block");
    AST_DRB_PULSE: assert property (drb_event && !drb_done |=> !drb_event)
        else $error("event too long");
endmodule // qwl_decoder_chk

bind qwl_decoder qwl_decoder_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drb_done(drb_done), .drb_event(drb_event));

/* tb/qwl_media_model.sv */
// Media and cache side model: completions, failures, data blocks
`timescale 1ns/1ps
module qwl_media_model (
    output logic       write_cache_on,
    output logic       media_done,
    output logic [4:0] media_done_slot,
    output logic       media_fail,
    output logic       drb_done,
    output logic       link_crc_err,
    input  wire logic  pclk
);
    initial begin
        write_cache_on = 1'b1;
        media_done = 1'b0;
        media_fail = 1'b0;
        media_done_slot = 5'h1F;
        drb_done = 1'b0;
        link_crc_err = 1'b0;
    end
    // Slot id valid only with a pulse; inverse shown after so stale ids fail
    task automatic finish_slot(input logic [4:0] s, input logic fail, input int lag);
        repeat (lag) @(posedge pclk);
        media_done_slot <= s;
        media_done <= !fail;
        media_fail <= fail;
        @(posedge pclk);
        media_done <= 1'b0;
        media_fail <= 1'b0;
        media_done_slot <= ~s;
    endtask
    task automatic blocks(input int n);
        repeat (n) begin
            drb_done <= 1'b1;
            @(posedge pclk);
            drb_done <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic crc_hit();
        link_crc_err <= 1'b1;
        @(posedge pclk);
        link_crc_err <= 1'b0;
    endtask
endmodule // qwl_media_model

/* tb/qwl_decoder_tb.sv */
// Testbench: queued write and log decoder driven over the register bus
`timescale 1ns/1ps
module queued_write_and_log_cmd_decoder_tb_top
    import qwl_pkg::*;
;
    localparam int         TICK  = 4;
    // Twelve edges lie between slot load and the entry read setup edge
    localparam int         HITS  = 12 / TICK;
    localparam logic [4:0] TG[5] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09};
    localparam logic [1:0] CL[5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
    localparam logic [7:0] DC[5] = '{8'h7F, 8'h82, 8'h05, 8'h90, 8'h00};
    localparam logic [4:0] FU    = 5'h01;
    localparam logic [35:0] LT[10] = '{36'h6_00_0000_04, 36'h6_04_0002_00, 36'h6_09_0000_04,
        36'h6_04_0005_04, 36'h7_01_0000_04, 36'h4_01_0000_04, 36'h2_01_0000_10,
        36'hE_01_0000_10, 36'h6_01_0100_04, 36'h6_04_0004_00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        wco, mdone, mfail, drb, crc, drb_event;
    logic [4:0]  mslot;
    int          bad_count = 0;
    int          checks = 0;
    int          nev = 0;

    always #50 pclk = ~pclk;
    always @(posedge pclk) if (drb_event === 1'b1) nev <= nev + 1;

    qwl_decoder #(.SLOTS(32), .TICK_CYC(TICK)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_cache_on(wco),
        .media_done(mdone), .media_done_slot(mslot), .media_fail(mfail), .drb_done(drb),
        .link_crc_err(crc), .drb_event(drb_event));
    qwl_media_model u_media (.pclk(pclk), .write_cache_on(wco), .media_done(mdone),
        .media_done_slot(mslot), .media_fail(mfail), .drb_done(drb), .link_crc_err(crc));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic go();
        xfer(1'b1, QWL_A_CTRL, 32'h1);
        for (int n = 0; n < 8; n++) begin
            xfer(1'b0, QWL_A_CTRL, 32'h0);
            if (rd[1] === 1'b0) break;
        end
        chk("busy", {31'h0, rd[1]}, 32'h0);
    endtask
    function automatic logic [14:0] tk(input logic [1:0] c, input logic [7:0] d);
        logic [13:0] b;
        b = d[7] ? (14'(d[6:0]) + 14'h1) * 14'(QWL_COARSE_MUL) : 14'(d[6:0]) + 14'h1;
        if (c != QWL_URGENCY_CLASS_ISO) return 15'h0;
        if (b > 14'(HITS)) return {1'b0, b - 14'(HITS)};
        return (b < 14'(HITS)) ? 15'h4000 : 15'h0;
    endfunction
    task automatic qw(input int i);
        xfer(1'b1, QWL_A_CMD, {24'h0, QWL_OP_QWRITE});
        xfer(1'b1, QWL_A_FEAT, 32'h0);
        xfer(1'b1, QWL_A_CNT, {16'h0, CL[i], 6'h0, TG[i], 3'h0});
        xfer(1'b1, QWL_A_LBALO, 32'h0ABC_0000 | 32'(i));
        xfer(1'b1, QWL_A_LBAHI, {16'h0, 16'h0100 | 16'(i)});
        xfer(1'b1, QWL_A_DEVDL, {16'h0, FU[i], 3'h4, 4'h0, DC[i]});
        go();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        for (int a = 0; a <= 32'h34; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        $display("reset test done");
    endtask
    task automatic t_queue();
        logic [14:0] t;
        for (int i = 0; i < 5; i++) begin
            qw(i);
            t = tk(CL[i], DC[i]);
            xfer(1'b1, QWL_A_SLOT, {27'h0, TG[i]});
            xfer(1'b0, QWL_A_SLOTLO, 32'h0);
            chk("slot lba", rd, 32'h0ABC_0000 | 32'(i));
            xfer(1'b0, QWL_A_SLOTHI, 32'h0);
            chk("slot entry", rd, {t[14], FU[i], CL[i], t[13:0], 14'(i) | 14'h0100});
        end
        xfer(1'b0, QWL_A_OUTST, 32'h0);
        chk("outstanding", rd, 32'h0000_03E0);
        xfer(1'b0, QWL_A_EVENT, 32'h0);
        chk("early ack", {31'h0, rd[1]}, 32'h1);
        xfer(1'b1, QWL_A_EVENT, 32'h3);
        u_media.finish_slot(5'h05, 1'b0, 3);
        xfer(1'b0, QWL_A_EVENT, 32'h0);
        chk("media event", rd, 32'h1);
        u_media.finish_slot(5'h06, 1'b1, 0);
        xfer(1'b0, QWL_A_RES, 32'h0);
        chk("fail status", rd, 32'h0000_0423);
        xfer(1'b0, QWL_A_OUTST, 32'h0);
        chk("retired", rd, 32'h0000_0380);
        $display("queue test done");
    endtask
    task automatic t_log();
        logic [35:0] c;
        int          n0;
        for (int i = 0; i < 10; i++) begin
            c = LT[i];
            xfer(1'b1, QWL_A_LOGCFG, {12'h0, c[35:32], 16'h0008});
            xfer(1'b1, QWL_A_CMD, {24'h0, QWL_OP_LOGWRITE});
            xfer(1'b1, QWL_A_CNT, {24'h0, c[31:24]});
            xfer(1'b1, QWL_A_LBALO, {16'h0, c[15:8], 8'hE0});
            xfer(1'b1, QWL_A_LBAHI, {24'h0, c[23:16]});
            go();
            xfer(1'b0, QWL_A_RES, 32'h0);
            chk("log error", {24'h0, rd[15:8]}, {24'h0, c[7:0]});
        end
        n0 = nev;
        u_media.blocks(3);
        @(posedge pclk);
        chk("block events", 32'(nev - n0), 32'h3);
        xfer(1'b1, QWL_A_CMD, {24'h0, QWL_OP_QWRITE});
        n0 = nev;
        u_media.blocks(2);
        @(posedge pclk);
        chk("stray events", 32'(nev - n0), 32'h0);
        $display("log test done");
    endtask
    task automatic t_bus();
        xfer(1'b0, 8'h3C, 32'h0);
        chk("unmapped data", rd, QWL_BAD_DATA);
        chk("unmapped read", {31'h0, serr}, 32'h1);
        xfer(1'b1, 8'h40, 32'h5);
        chk("unmapped write", {31'h0, serr}, 32'h1);
        xfer(1'b1, QWL_A_CMD, 32'hFFFF_FF35);
        xfer(1'b0, QWL_A_CMD, 32'h0);
        chk("command width", rd, 32'h35);
        u_media.crc_hit();
        xfer(1'b0, QWL_A_RES, 32'h0);
        chk("link error", {30'h0, rd[15], rd[0]}, 32'h3);
        $display("bus test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_queue();
        t_log();
        t_bus();
        summarize();
    end
    // Whole run needs about 600 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        summarize();
    end
endmodule // queued_write_and_log_cmd_decoder_tb_top
